// [pev_eeprom_ctl.v]
// Operation
// R1: whole 20-bit holding register written to store in one parallel step
// R2: write leaves each stored bit as old bit AND holding bit
// R3: programmer erases with strobe, select, load high and 25 ms pulse
// R4: programmer writes with strobe high, select low and 25 ms pulse
// R5: programmer loads holding register serially before the write
// R6: programmer ends programming by driving load control low
// R7: programmer avoids toggling load control between load and write
// R8: order is load, erase, then write
// R9: with relays, at least 100 ms between erase and write pulses
// R10: verify needs enhancement bit 1 set to show holding register
// R11: verify runs twice: flush old contents, then read stored word
// R12: each read-back pass uses 19 clocks; bit 0 shows before them
// R13: enhancement enable held low through the whole read-back
// R14: store copied into holding register on delayed select rising edge
// R15: copy on select rise with load low, or while load is high; code copies with load high only while strobe is low
// R16: read-out shifts LSB first on serial clock rise, data in behind
// R17: enhancement settings take effect on strobe falling edge
// R18: control lines stay stable throughout each programming pulse
//
// Added by the designer: the pin synchronisers and debounce stages.
`default_nettype none
`include "pev_regs.vh"
module pev_eeprom_ctl #(
    // shortest accepted pulse in mclk cycles, 25 ms by default
    parameter PULSE_CYC = `PEV_PULSE_MIN_CYC
) (
    input wire mclk,
    input wire rst,
    input wire serial_clk,
    input wire serial_data_in,
    input wire secondary_write_strobe,
    input wire enhancement_write_strobe,
    input wire enhancement_enable_n,
    input wire nv_register_select,
    input wire nv_load_control,
    input wire vpp_erase,
    input wire vpp_write,
    output reg serial_data_out,
    output reg [19:0] nv_word,
    output reg [7:0] enh_active,
    output reg pulse_fault
);
    // ======================================================
    // three-stage pin synchronisers
    reg [2:0] sclk_s, sdi_s, swr_s, ewr_s, enh_s, sel_s, ld_s, ve_s, vw_s;
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            sclk_s <= 3'h0;
            sdi_s <= 3'h0;
            swr_s <= 3'h0;
            ewr_s <= 3'h0;
            enh_s <= 3'h7;
            sel_s <= 3'h0;
            ld_s <= 3'h0;
            ve_s <= 3'h0;
            vw_s <= 3'h0;
        end else begin
            sclk_s <= {sclk_s[1:0], serial_clk};
            sdi_s <= {sdi_s[1:0], serial_data_in};
            swr_s <= {swr_s[1:0], secondary_write_strobe};
            ewr_s <= {ewr_s[1:0], enhancement_write_strobe};
            enh_s <= {enh_s[1:0], enhancement_enable_n};
            sel_s <= {sel_s[1:0], nv_register_select};
            ld_s <= {ld_s[1:0], nv_load_control};
            ve_s <= {ve_s[1:0], vpp_erase};
            vw_s <= {vw_s[1:0], vpp_write};
        end
    end

    // ======================================================
    // debounced levels: change accepted when stages 2 and 3 agree
    reg sclk_q, sdi_q, swr_q, ewr_q, enh_n_q, sel_q, ld_q, ve_q, vw_q;
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            sclk_q <= 1'b0;
            sdi_q <= 1'b0;
            swr_q <= 1'b0;
            ewr_q <= 1'b0;
            enh_n_q <= 1'b1;
            sel_q <= 1'b0;
            ld_q <= 1'b0;
            ve_q <= 1'b0;
            vw_q <= 1'b0;
        end else begin
            if (sclk_s[1] == sclk_s[2]) sclk_q <= sclk_s[2];
            if (sdi_s[1] == sdi_s[2]) sdi_q <= sdi_s[2];
            if (swr_s[1] == swr_s[2]) swr_q <= swr_s[2];
            if (ewr_s[1] == ewr_s[2]) ewr_q <= ewr_s[2];
            if (enh_s[1] == enh_s[2]) enh_n_q <= enh_s[2];
            if (sel_s[1] == sel_s[2]) sel_q <= sel_s[2];
            if (ld_s[1] == ld_s[2]) ld_q <= ld_s[2];
            if (ve_s[1] == ve_s[2]) ve_q <= ve_s[2];
            if (vw_s[1] == vw_s[2]) vw_q <= vw_s[2];
        end
    end

    // ======================================================
    // edge detection on the cleaned levels
    reg sclk_d, ewr_d, sel_d, pul_d;
    wire pulse_on = ve_q | vw_q;
    wire sclk_rise = sclk_q & ~sclk_d;
    wire ewr_fall = ~ewr_q & ewr_d;
    wire sel_rise = sel_q & ~sel_d;
    wire pulse_end = ~pulse_on & pul_d;
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            sclk_d <= 1'b0;
            ewr_d <= 1'b0;
            sel_d <= 1'b0;
            pul_d <= 1'b0;
        end else begin
            sclk_d <= sclk_q;
            ewr_d <= ewr_q;
            sel_d <= sel_q;
            pul_d <= pulse_on;
        end
    end

    // ======================================================
    // programming pulse sequencer
    localparam ST_IDLE = 3'b001;
    localparam ST_ERASE = 3'b010;
    localparam ST_WRITE = 3'b100;
    reg [2:0] st_reg, st_next;
    reg [`PEV_CNT_W-1:0] cnt_reg;
    reg erase_stb, write_stb;
    wire erase_cond = swr_q & sel_q & ld_q & ve_q & ~vw_q; // R3
    wire write_cond = swr_q & ~sel_q & ld_q & vw_q & ~ve_q; // R4
    wire cnt_done = (cnt_reg >= PULSE_CYC);

    // next state: pulse commits only after its full length
    always @* begin
        st_next = st_reg;
        erase_stb = 1'b0;
        write_stb = 1'b0;
        case (st_reg)
            ST_IDLE: begin
                if (erase_cond) st_next = ST_ERASE;
                else if (write_cond) st_next = ST_WRITE;
            end
            ST_ERASE: begin
                if (pulse_end) begin
                    erase_stb = cnt_done; // R3
                    st_next = ST_IDLE;
                end else if (!erase_cond) begin
                    st_next = ST_IDLE; // R18
                end
            end
            ST_WRITE: begin
                if (pulse_end) begin
                    write_stb = cnt_done; // R1 R4
                    st_next = ST_IDLE;
                end else if (!write_cond) begin
                    st_next = ST_IDLE; // R18
                end
            end
            default: st_next = ST_IDLE;
        endcase
    end

    // state, pulse length counter and fault flag
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_reg <= ST_IDLE;
            cnt_reg <= `PEV_CNT_ZERO;
            pulse_fault <= 1'b0;
        end else begin
            st_reg <= st_next;
            // entry cycle counts, so a pulse of exactly PULSE_CYC passes
            if (st_next == ST_IDLE) cnt_reg <= `PEV_CNT_ZERO;
            else if (!cnt_done) cnt_reg <= cnt_reg + `PEV_CNT_ONE;
            if (erase_stb | write_stb) pulse_fault <= 1'b0;
            else if (st_reg != ST_IDLE && st_next == ST_IDLE)
                pulse_fault <= 1'b1; // R18
        end
    end

    // ======================================================
    // store array
    wire [19:0] store_q;
    pev_nv_store u_store (
        .mclk(mclk),
        .rst(rst),
        .erase_stb(erase_stb),
        .write_stb(write_stb),
        .wr_data(nv_word),
        .rd_data(store_q)
    );

    // ======================================================
    // enhancement shift register with buffer
    reg [7:0] enh_shift_reg;
    wire enh_load = sclk_rise & ~swr_q & ewr_q & ~ld_q;
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            enh_shift_reg <= `PEV_ENH_RST;
            enh_active <= `PEV_ENH_RST;
        end else begin
            if (enh_load)
                enh_shift_reg <= {sdi_q, enh_shift_reg[7:1]};
            if (ewr_fall) enh_active <= enh_shift_reg; // R17
        end
    end

    // ======================================================
    // holding register: copy, serial load, read-out shift
    wire readout = ~enh_n_q & enh_active[`PEV_ENH_NV_OUT]; // R10 R13
    wire copy_now = (sel_rise & ~ld_q) | (ld_q & ~swr_q); // R14 R15
    wire nv_shift = sclk_rise & ~swr_q & ((ld_q & ~copy_now) | readout);
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            nv_word <= `PEV_NV_RST;
            serial_data_out <= 1'b0;
        end else begin
            if (copy_now) nv_word <= store_q;
            else if (nv_shift)
                nv_word <= {sdi_q, nv_word[19:1]}; // R16 R12
            serial_data_out <= readout ? nv_word[0] : 1'b0; // R12
        end
    end
endmodule // pev_eeprom_ctl
`default_nettype wire

// [pev_eeprom_ctl_asserts.sv]
`default_nettype none
// ====================
// pin checks of the store controller
module pev_ctl_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic serial_clk,
    input wire logic serial_data_in,
    input wire logic secondary_write_strobe,
    input wire logic enhancement_write_strobe,
    input wire logic enhancement_enable_n,
    input wire logic nv_register_select,
    input wire logic nv_load_control,
    input wire logic vpp_erase,
    input wire logic vpp_write,
    input wire logic serial_data_out,
    input wire logic [19:0] nv_word,
    input wire logic [7:0] enh_active,
    input wire logic pulse_fault
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    // outputs tied to the pins that cause them
    property p_eh; enhancement_write_strobe [*8] |-> $stable(enh_active);
    endproperty
    a_eh: assert property (p_eh) else $error("enh early");
    property p_el; !enhancement_write_strobe [*8] |-> $stable(enh_active);
    endproperty
    a_el: assert property (p_el) else $error("enh late");
    property p_idle; ($stable({serial_clk, nv_register_select,
        nv_load_control, secondary_write_strobe}) && !vpp_write
        && !vpp_erase) [*8] |-> $stable(nv_word);
    endproperty
    a_idle: assert property (p_idle) else $error("word moved");
    property p_prog; (secondary_write_strobe && nv_load_control) [*8]
        |-> $stable(nv_word);
    endproperty
    a_prog: assert property (p_prog) else $error("word hit");
    property p_short; ($rose(vpp_write) && secondary_write_strobe
        && nv_load_control && !nv_register_select)
        ##1 vpp_write [*8] ##1 !vpp_write |-> ##[1:12] pulse_fault;
    endproperty
    a_short: assert property (p_short) else $error("no fault");
    property p_off; (enhancement_enable_n || !enh_active[1]) [*8]
        |-> !serial_data_out;
    endproperty
    a_off: assert property (p_off) else $error("dout on");
    property p_bit0; (!enhancement_enable_n && enh_active[1]) [*8]
        |-> serial_data_out == $past(nv_word[0]);
    endproperty
    a_bit0: assert property (p_bit0) else $error("dout bad");
    property p_shift; (!nv_register_select && !nv_load_control) [*8]
        ##1 $changed(nv_word) |-> nv_word[18:0] == $past(nv_word[19:1]);
    endproperty
    a_shift: assert property (p_shift) else $error("bad shift");
    c_fault: cover property ($rose(pulse_fault));
    c_copy: cover property ($rose(nv_register_select));
    c_enh: cover property ($fell(enhancement_write_strobe));
    c_erase: cover property ($fell(vpp_erase));
endmodule // pev_ctl_chk
bind pev_eeprom_ctl pev_ctl_chk u_chk (
    .mclk(mclk),
    .rst(rst),
    .serial_clk(serial_clk),
    .serial_data_in(serial_data_in),
    .secondary_write_strobe(secondary_write_strobe),
    .enhancement_write_strobe(enhancement_write_strobe),
    .enhancement_enable_n(enhancement_enable_n),
    .nv_register_select(nv_register_select),
    .nv_load_control(nv_load_control),
    .vpp_erase(vpp_erase),
    .vpp_write(vpp_write),
    .serial_data_out(serial_data_out),
    .nv_word(nv_word),
    .enh_active(enh_active),
    .pulse_fault(pulse_fault)
);
`default_nettype wire

// [pev_nv_store.v]
`default_nettype none
// ==========================================================
// non-volatile store array, registered read data
module pev_nv_store (
    input wire mclk,
    input wire rst,
    input wire erase_stb,
    input wire write_stb,
    input wire [19:0] wr_data,
    output reg [19:0] rd_data
);
    reg [19:0] cell_reg;
    genvar i;

    // erase sets every cell; write ANDs each cell with its data bit
    generate
        for (i = 0; i < 20; i = i + 1) begin : g_cell
            always @(posedge mclk or posedge rst) begin
                if (rst) begin
                    cell_reg[i] <= 1'b1;
                end else if (erase_stb) begin
                    cell_reg[i] <= 1'b1;
                end else if (write_stb) begin
                    cell_reg[i] <= cell_reg[i] & wr_data[i]; // R2 R1
                end
            end
        end
    endgenerate

    // read port registered
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_data <= 20'h00000;
        end else begin
            rd_data <= cell_reg;
        end
    end
endmodule // pev_nv_store
`default_nettype wire

// [pev_prog_model.sv]
`default_nettype none
// ====================
// programmer driving control pins and pulses
module pev_prog_model (
    input wire logic mclk,
    output logic serial_clk,
    output logic serial_data_in,
    output logic secondary_write_strobe,
    output logic enhancement_write_strobe,
    output logic enhancement_enable_n,
    output logic nv_register_select,
    output logic nv_load_control,
    output logic vpp_erase,
    output logic vpp_write
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle pins, enhancement off until set
    initial begin
        {serial_clk, serial_data_in, secondary_write_strobe} = 3'h0;
        {enhancement_write_strobe, nv_register_select} = 2'h0;
        {nv_load_control, vpp_erase, vpp_write} = 3'h0;
        enhancement_enable_n = 1'b1;
    end
    // one 320 ns clock, data a cycle ahead of the rise
    task automatic sclk(input logic d);
        serial_data_in <= d;
        @(posedge mclk) serial_clk <= 1'b1;
        repeat (4) @(posedge mclk);
        serial_clk <= 1'b0;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    // enable_n, strobe, enh strobe, select, load
    task automatic pins(input logic [4:0] v);
        {enhancement_enable_n, secondary_write_strobe,
            enhancement_write_strobe, nv_register_select,
            nv_load_control} <= v;
        repeat (10) @(posedge mclk);
        #1;
    endtask
    // erase or write pulse, control lines left alone meanwhile
    task automatic vpp(input logic erase, input int n);
        if (erase) vpp_erase <= 1'b1;
        else vpp_write <= 1'b1;
        repeat (n) @(posedge mclk);
        vpp_erase <= 1'b0;
        vpp_write <= 1'b0;
        repeat (20) @(posedge mclk);
        #1;
    endtask
endmodule // pev_prog_model
`default_nettype wire

// [pev_regs.vh]
`ifndef PEV_REGS_VH
`define PEV_REGS_VH
// ==========================================================
// widths and field positions
`define PEV_NV_W 20
`define PEV_NV_MSB 19
`define PEV_ENH_W 8
`define PEV_ENH_MSB 7
`define PEV_ENH_NV_OUT 1
// ==========================================================
// reset values
`define PEV_NV_RST 20'h00000
`define PEV_ENH_RST 8'h00
// ==========================================================
// programming pulse timing at 25 MHz
`define PEV_PULSE_MS 25
`define PEV_CLK_KHZ 25000
`define PEV_PULSE_MIN_CYC 625000
`define PEV_CNT_W 20
`define PEV_CNT_ZERO 20'h00000
`define PEV_CNT_ONE 20'h00001
`define PEV_LOG2_ONE 1'b1
`endif

// [test_pev_eeprom_ctl.sv]
`default_nettype none
// ====================
// load, refused pulse and read-back run
module test_pev_eeprom_ctl;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [19:0] W = 20'h5a3c6;
    localparam logic [19:0] W2 = 20'h0f0f0;
    // short pulse length so a full pulse fits the run
    localparam int PULSE_SIM = 50;
    logic mclk;
    logic rst;
    int miscompares;
    int n_tests;
    wire serial_clk, serial_data_in, secondary_write_strobe;
    wire enhancement_write_strobe, enhancement_enable_n;
    wire nv_register_select, nv_load_control, vpp_erase, vpp_write;
    wire serial_data_out, pulse_fault;
    wire [19:0] nv_word;
    wire [7:0] enh_active;
    pev_prog_model prog (
        .mclk(mclk),
        .serial_clk(serial_clk),
        .serial_data_in(serial_data_in),
        .secondary_write_strobe(secondary_write_strobe),
        .enhancement_write_strobe(enhancement_write_strobe),
        .enhancement_enable_n(enhancement_enable_n),
        .nv_register_select(nv_register_select),
        .nv_load_control(nv_load_control),
        .vpp_erase(vpp_erase),
        .vpp_write(vpp_write)
    );
    pev_eeprom_ctl #(.PULSE_CYC(PULSE_SIM)) DUT (
        .mclk(mclk),
        .rst(rst),
        .serial_clk(serial_clk),
        .serial_data_in(serial_data_in),
        .secondary_write_strobe(secondary_write_strobe),
        .enhancement_write_strobe(enhancement_write_strobe),
        .enhancement_enable_n(enhancement_enable_n),
        .nv_register_select(nv_register_select),
        .nv_load_control(nv_load_control),
        .vpp_erase(vpp_erase),
        .vpp_write(vpp_write),
        .serial_data_out(serial_data_out),
        .nv_word(nv_word),
        .enh_active(enh_active),
        .pulse_fault(pulse_fault)
    );
    // 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic stop_test();
        if (miscompares == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic cmp_word(input logic [19:0] got, input logic [19:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t word %h not %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t bit %b not %b", $time, got, exp);
        end
    endtask
    // one read-back pass: check dout, then clock the next bit
    task automatic pass(input logic [19:0] exp, din, input int n);
        for (int i = 0; i < 20; i++) begin
            cmp_bit(serial_data_out, exp[i]);
            if (i < n) prog.sclk(din[i]);
        end
    endtask
    // main sequence
    initial begin
        rst = 1'b1;
        miscompares = 0;
        n_tests = 0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        prog.pins(5'b10100);
        for (int i = 0; i < 8; i++) prog.sclk(i == 1);
        cmp_word({12'h000, enh_active}, 20'h00000);
        prog.pins(5'b10000);
        cmp_word({12'h000, enh_active}, 20'h00002);
        prog.pins(5'b10010);
        cmp_word(nv_word, 20'hfffff);
        cmp_bit(serial_data_out, 1'b0);
        prog.pins(5'b00010);
        prog.pins(5'b00000);
        pass(20'hfffff, W, 20);
        cmp_word(nv_word, W);
        prog.pins(5'b01001);
        prog.vpp(1'b0, 9);
        cmp_bit(pulse_fault, 1'b1);
        cmp_word(nv_word, W);
        prog.pins(5'b01011);
        prog.vpp(1'b1, PULSE_SIM);
        cmp_bit(pulse_fault, 1'b0);
        prog.pins(5'b01001);
        prog.vpp(1'b0, PULSE_SIM);
        cmp_bit(pulse_fault, 1'b0);
        cmp_word(nv_word, W);
        prog.pins(5'b00000);
        pass(W, 20'hfffff, 19);
        cmp_word(nv_word, 20'hffffe);
        prog.pins(5'b00001);
        cmp_word(nv_word, W);
        prog.pins(5'b00000);
        pass(W, 20'h00000, 19);
        pass(20'h00000, W2, 20);
        cmp_word(nv_word, W2);
        prog.pins(5'b01001);
        prog.vpp(1'b0, PULSE_SIM);
        cmp_bit(pulse_fault, 1'b0);
        prog.pins(5'b00000);
        prog.pins(5'b00001);
        cmp_word(nv_word, 20'h0a0c0);
        stop_test();
    end
endmodule // test_pev_eeprom_ctl
`default_nettype wire
